// ### core/rml_pkg.sv
// constants and types for the reset, boot-strap latch and external request block
package rml_pkg;
    // ==========================================================
    // widths
    localparam int unsigned NUM_PINS   = 4;
    localparam int unsigned MODE_W     = 4;
    localparam int unsigned CNT_W      = 3;
    // ==========================================================
    // reset values
    localparam logic [NUM_PINS-1:0] PIN_IDLE   = 4'hf;
    localparam logic [NUM_PINS-1:0] PEND_RST   = 4'h0;
    localparam logic [MODE_W-1:0]   MODE_RST   = 4'h0;
    localparam logic [CNT_W-1:0]    CNT_RST    = 3'h0;
    // ==========================================================
    // start-up timing, in core clock edges after reset release
    localparam logic [CNT_W-1:0]    START_LAST = 3'h2;
    localparam int unsigned         START_CYC  = 3;
    // ==========================================================
    // phases of the block
    typedef enum logic [0:0] {
        RML_BOOT = 1'b0,
        RML_RUN  = 1'b1
    } rml_phase_e;
endpackage

// ### core/rml_top.sv
// reset sequencing, boot-strap latch and external interrupt request inputs
`timescale 1ns/1ns

module rml_top (
    input  wire logic                           clk_sys_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           boot_strap_a_int_req_n_i,
    input  wire logic                           boot_strap_b_int_req_n_i,
    input  wire logic                           boot_strap_c_int_req_n_i,
    input  wire logic                           boot_strap_d_int_req_n_i,
    input  wire logic [rml_pkg::NUM_PINS-1:0]   irq_edge_mode_i,
    input  wire logic [rml_pkg::NUM_PINS-1:0]   irq_enable_i,
    input  wire logic [rml_pkg::NUM_PINS-1:0]   irq_ack_i,
    input  wire logic                           in_wait_i,
    input  wire logic                           in_stop_i,
    output logic      [rml_pkg::MODE_W-1:0]     operating_mode_register_o,
    output logic      [rml_pkg::NUM_PINS-1:0]   irq_req_o,
    output logic                                wake_wait_o,
    output logic                                wake_stop_o,
    output logic                                phase_gen_rst_o,
    output logic                                core_run_o
);
    import rml_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic [NUM_PINS-1:0] prev;
        logic [NUM_PINS-1:0] pend;
        logic [MODE_W-1:0]   mode;
        logic [CNT_W-1:0]    cnt;
        rml_phase_e          phase;
    } rml_state_s;

    rml_state_s              s_q;
    rml_state_s              s_d;
    logic [NUM_PINS-1:0]     pins_n;
    logic [NUM_PINS-1:0]     active;
    logic [NUM_PINS-1:0]     fall;
    logic                    run;

    assign pins_n = {boot_strap_d_int_req_n_i, boot_strap_c_int_req_n_i,
                     boot_strap_b_int_req_n_i, boot_strap_a_int_req_n_i};
    assign run    = (s_q.phase == RML_RUN);
    // active low pins, read only after the second stage
    assign active = ~s_q.sync2;
    // edge seen between the second stage and the copy behind it
    assign fall   = s_q.prev & ~s_q.sync2;

    // ==========================================================
    // next state
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = pins_n;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        case (s_q.phase)
            RML_BOOT: begin
                // pins are still straps here, so no edge may be latched
                s_d.pend = PEND_RST;
                s_d.cnt  = s_q.cnt + 3'h1;
                // latch strap code once synchroniser is full
                // fixed count, so lock-stepped parts start together
                if (s_q.cnt == START_LAST) begin
                    s_d.mode  = s_q.sync2;
                    s_d.phase = RML_RUN;
                end
            end
            RML_RUN: begin
                // edge capture; a new edge beats an ack in the same cycle
                s_d.pend = (s_q.pend & ~irq_ack_i) | (fall & irq_edge_mode_i);
                // mode code is not touched again until reset
            end
            default: begin
                // unreachable code; fall back to the strap phase
                s_d.phase = RML_BOOT;
            end
        endcase
    end

    // ==========================================================
    // registers; reset is the only way back to the strap phase
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.sync1 <= PIN_IDLE;
            s_q.sync2 <= PIN_IDLE;
            s_q.prev  <= PIN_IDLE;
            s_q.pend  <= PEND_RST;
            s_q.mode  <= MODE_RST;
            s_q.cnt   <= CNT_RST;
            s_q.phase <= RML_BOOT;
        end else begin
            // mode keeps its value through run; only reset clears it
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign operating_mode_register_o = s_q.mode;
    // no requests while pins still act as straps
    // level or latched edge, gated by the enable
    assign irq_req_o = run ? (irq_enable_i &
                       ((irq_edge_mode_i & s_q.pend) | (~irq_edge_mode_i & active)))
                       : PEND_RST;
    // combinational wake paths: standby may end in the same clock
    // any asserted pin ends wait, masked or not
    assign wake_wait_o = run & in_wait_i & (|active);
    assign wake_stop_o = run & in_stop_i & active[0];
    // phase generator held until start-up completes
    assign phase_gen_rst_o = ~run;
    assign core_run_o      = run;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // saturating cycle count since release, for the start-up check
    logic [CNT_W-1:0] chk_cyc_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chk_cyc_q <= CNT_RST;
        end else if (chk_cyc_q != 3'h7) begin
            chk_cyc_q <= chk_cyc_q + 3'h1;
        end
    end

    sequence seq_fall_a;
        run && irq_edge_mode_i[0] && s_q.prev[0] && !s_q.sync2[0];
    endsequence
    sequence seq_req_a_held;
        irq_req_o[0] || !irq_enable_i[0];
    endsequence

    AST_STRAP_QUIET: assert property (!core_run_o |-> irq_req_o == PEND_RST)
        else $error("request raised during strap phase");
    AST_MODE_LATCH: assert property (
        (!run && s_q.cnt == START_LAST) |=> operating_mode_register_o == $past(pins_n, 3))
        else $error("mode code differs from strap levels");
    AST_SYNC_DELAY: assert property (
        ($past(run, 2) && run && !irq_edge_mode_i[0] && irq_enable_i[0])
        |-> irq_req_o[0] == !$past(boot_strap_a_int_req_n_i, 2))
        else $error("level request not two clocks behind pin");
    AST_EDGE_CATCH: assert property (
        (seq_fall_a ##0 !irq_ack_i[0]) |=> (seq_req_a_held))
        else $error("falling edge lost");
    AST_MASKED: assert property ((irq_req_o & ~irq_enable_i) == PEND_RST)
        else $error("masked request visible");
    AST_WAIT_EXIT: assert property (
        (run && in_wait_i && s_q.sync2 != PIN_IDLE) |-> wake_wait_o)
        else $error("wait not ended by asserted pin");
    AST_STOP_EXIT: assert property (
        (run && in_stop_i && !s_q.sync2[0]) |-> wake_stop_o && !wake_wait_o == !in_wait_i)
        else $error("stop not ended by first pin");
    AST_PHASE_GEN: assert property (phase_gen_rst_o |-> !core_run_o ##0 !wake_stop_o)
        else $error("phase generator released while held");
    AST_START_COUNT: assert property (
        core_run_o == (chk_cyc_q >= 3'(START_CYC)))
        else $error("start-up count not fixed");
    AST_MODE_HOLD: assert property (
        (run && $past(run)) |-> $stable(operating_mode_register_o) ##1 core_run_o)
        else $error("mode code changed after start-up");

    // ==========================================================
    // further checks on the request, wake and start-up paths
    sequence seq_ack_a;
        run && irq_ack_i[0] && !(s_q.prev[0] && !s_q.sync2[0]);
    endsequence
    sequence seq_quiet_a;
        run && !s_q.pend[0] && !(s_q.prev[0] && !s_q.sync2[0]);
    endsequence
    sequence seq_release;
        !run && s_q.cnt == START_LAST;
    endsequence
    sequence seq_started;
        core_run_o && !phase_gen_rst_o;
    endsequence

    // an ack with no fresh edge in the same cycle must empty the latch
    AST_ACK_CLEAR: assert property (seq_ack_a |=> !s_q.pend[0])
        else $error("edge request not cleared by ack");

    // a rising or steady pin never creates an edge request
    AST_NO_FALSE_EDGE: assert property (seq_quiet_a |=> !s_q.pend[0])
        else $error("edge request without falling pin");

    AST_LEVEL_FOLLOW: assert property (
        (run && !irq_edge_mode_i[1] && irq_enable_i[1]) |-> irq_req_o[1] == !s_q.sync2[1])
        else $error("level request does not follow pin");

    AST_BOOT_NO_PEND: assert property (!run |-> s_q.pend == PEND_RST)
        else $error("edge request latched during strap phase");

    AST_WAIT_QUIET: assert property (
        (!in_wait_i || s_q.sync2 == PIN_IDLE) |-> !wake_wait_o)
        else $error("wait ended with no asserted pin");

    AST_STOP_QUIET: assert property ((!in_stop_i || s_q.sync2[0]) |-> !wake_stop_o)
        else $error("stop ended with first pin high");

    // start-up is one step: core runs and phase generator is freed together
    AST_START_SEQ: assert property (seq_release |=> seq_started)
        else $error("start-up did not complete on the fixed edge");
endmodule // rml_top

// ### bench/rml_board.sv
// board model: reset source and pulled-up strap and request pins
`timescale 1ns/1ns
module rml_board (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_req_i,
    input  wire logic [3:0] pull_low_i,
    output logic            rst_n_o,
    output logic [3:0]      pin_o
);
    // ==========================================
    // reset and pins
    // low from power-up on
    logic rst_q = 1'b0;
    // released in step with the clock
    always @(posedge clk_sys_i) rst_q <= ~rst_req_i;
    assign rst_n_o = rst_q;
    // pull-ups take a released pin high
    assign pin_o = ~pull_low_i;
endmodule // rml_board

// ### bench/tb.sv
// self-checking bench for the reset, strap latch and request block
`timescale 1ns/1ns
module tb;
    import rml_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rq = 1'b1, iw = 1'b0, is = 1'b0, rst_n, ww, ws, pgr, run;
    logic [3:0] drv = 4'h0, em = 4'h0, en = 4'h0, ack = 4'h0, p, mode, req;
    int bad_count = 0, n_checks = 0, cyc = 0;
    // ==========================================
    // clock, board and design
    // clock runs through reset
    initial forever #10 clk_sys_i = ~clk_sys_i;
    rml_board u_rml_board (.clk_sys_i(clk_sys_i), .rst_req_i(rq), .pull_low_i(drv),
        .rst_n_o(rst_n), .pin_o(p));
    rml_top u_rml_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n),
        .boot_strap_a_int_req_n_i(p[0]), .boot_strap_b_int_req_n_i(p[1]),
        .boot_strap_c_int_req_n_i(p[2]), .boot_strap_d_int_req_n_i(p[3]),
        .irq_edge_mode_i(em), .irq_enable_i(en), .irq_ack_i(ack), .in_wait_i(iw),
        .in_stop_i(is), .operating_mode_register_o(mode), .irq_req_o(req),
        .wake_wait_o(ww), .wake_stop_o(ws), .phase_gen_rst_o(pgr), .core_run_o(run));
    // ==========================================
    // helpers
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        // hang limit, over forty times the expected run
        if (cyc == 3000) begin
            bad_count++;
            test_done;
        end
    end
    // ==========================================
    // scenarios
    task automatic boot(logic [3:0] code);
        @(posedge clk_sys_i);
        rq <= 1'b1;
        en <= 4'hf;
        drv <= ~code;
        tick(3);
        chk("reset_held", 4'h2, {2'h0, pgr, run});
        chk("req_in_reset", 4'h0, req);
        @(posedge clk_sys_i);
        rq <= 1'b0;
        tick(3);
        chk("not_started", 4'h2, {2'h0, pgr, run});
        tick(1);
        chk("mode", code, mode);
        chk("started", 4'h1, {2'h0, pgr, run});
        @(posedge clk_sys_i);
        drv <= 4'h0;
        en <= 4'h0;
    endtask
    task automatic lvl_wake;
        @(posedge clk_sys_i);
        en <= 4'h3;
        drv <= 4'ha;
        iw <= 1'b1;
        is <= 1'b1;
        tick(4);
        chk("req_lvl", 4'h2, req);
        chk("wake_d", 4'h1, {2'h0, ws, ww});
        @(posedge clk_sys_i);
        en <= 4'h0;
        drv <= 4'h1;
        tick(4);
        chk("masked", 4'h0, req);
        chk("wake_a", 4'h3, {2'h0, ws, ww});
        @(posedge clk_sys_i);
        drv <= 4'h0;
        en <= 4'h3;
        tick(4);
        chk("pins_high", 4'h0, {1'h0, ws, ww, req[1]});
        @(posedge clk_sys_i);
        iw <= 1'b0;
        is <= 1'b0;
    endtask
    task automatic edge_req;
        @(posedge clk_sys_i);
        em <= 4'h1;
        en <= 4'h1;
        drv <= 4'h1;
        tick(3);
        @(posedge clk_sys_i);
        drv <= 4'h0;
        tick(4);
        chk("edge_pend", 4'h1, req);
        @(posedge clk_sys_i);
        ack <= 4'h1;
        @(posedge clk_sys_i);
        ack <= 4'h0;
        tick(1);
        chk("edge_ack", 4'h0, req);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        boot(4'ha);
        lvl_wake;
        edge_req;
        chk("mode_kept", 4'ha, mode);
        boot(4'h5);
        test_done;
    end
endmodule // tb
